// ### hw/irq_gpio_pkg.sv
// shared constants, register map and carrier types for event routing and pins
package irq_gpio_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int NUM_PINS = 4;

  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_PIN_CFG0 = 8'h08;
  localparam logic [7:0] ADDR_PIN_STRIDE = 8'h04;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h18;

  // event vector bit positions
  localparam int EVB_TX_SENT = 2;
  localparam int EVB_FIFO_ERR = 5;
  localparam int EVB_FIFO_AFULL = 7;
  localparam int EVB_FIFO_AEMPTY = 8;
  localparam int EVB_READY = 16;
  localparam int EVB_STANDBY_SW = 17;
  localparam int EVB_LOW_BATT = 18;
  localparam int EVB_POR = 19;
  localparam int EVB_BROWNOUT = 20;
  localparam int EVB_LOCK = 21;
  localparam int EVB_CIPHER_DONE = 30;
  localparam logic [31:0] EVT_USED_MASK = 32'h403F_01A4;

  // values after reset
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [7:0] PIN_CFG_RESET = 8'hA2;

  // pin direction field
  localparam logic [1:0] MODE_IN = 2'h1;
  localparam logic [1:0] MODE_OUT_LP = 2'h2;
  localparam logic [1:0] MODE_OUT_HP = 2'h3;

  // input selection codes
  localparam logic [4:0] ISEL_TX_CMD = 5'h00;
  localparam logic [4:0] ISEL_DIRECT_DATA = 5'h02;
  localparam logic [4:0] ISEL_WAKEUP = 5'h03;
  localparam logic [4:0] ISEL_EXT_CLK = 5'h04;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-pin configuration word
  typedef struct packed {
    logic [4:0] sel;
    logic rsvd;
    logic [1:0] mode;
  } pin_cfg_t;

  // one-cycle event pulses from the device core
  typedef struct packed {
    logic tx_sent;
    logic fifo_err;
    logic fifo_afull;
    logic fifo_aempty;
    logic osc_ready;
    logic standby_sw;
    logic low_batt;
    logic por;
    logic brownout;
    logic lock;
    logic cipher_done;
  } evt_t;

  // state levels from the device core, offered on output pins
  typedef struct packed {
    logic por_active;
    logic wakeup_timer_expired;
    logic low_batt;
    logic tx_data_clk;
    logic tx_state;
    logic fifo_aempty;
    logic fifo_afull;
    logic range_ext_tx;
    logic switching_regulator_en;
    logic sleep_or_standby;
    logic ready_state;
    logic lock_state;
    logic wait_lock_det;
    logic wait_lock_timer;
    logic wait_osc_settled_signal;
    logic wait_pm_settle;
    logic wait_vco_cal;
    logic synthesizer_full_en;
    logic wait_rc_cal_done;
  } ind_t;

endpackage

// ### hw/event_latch.sv
// sticky event flags with read-clear, set beats clear
`timescale 1ns/1ps
`default_nettype none
module event_latch
  import irq_gpio_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // set and clear masks
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // latched flags
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // a new event in the clearing cycle survives the clear
  always_comb begin
    flags_next = (flags_reg & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= W'(STATUS_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_set_holds: assert property ((|set) |=> ((flags & $past(set)) == $past(set)))
    else $error("event flag not latched");

endmodule // event_latch
`default_nettype wire

// ### hw/pin_cell.sv
// one general-purpose pin: output selection, direction and input synchroniser
`timescale 1ns/1ps
`default_nettype none
module pin_cell
  import irq_gpio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration and selectable signals
  input wire pin_cfg_t cfg,
  input wire logic [31:0] out_vec,
  // pad side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_hp,
  // synchronised level, zero unless configured as input
  output logic in_level
);

  logic out_reg, out_next, oe_reg, oe_next, hp_reg, hp_next;
  logic s1_reg, s1_next, s2_reg, s2_next;
  logic sel_bit;

  assign sel_bit = out_vec[cfg.sel];

  always_comb begin
    oe_next = cfg.mode[1];
    hp_next = (cfg.mode == MODE_OUT_HP);
    out_next = cfg.mode[1] & sel_bit;
    s1_next = pin_in;
    s2_next = s1_reg;
  end

  // the pad is asynchronous, so two stages before anything reads it
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      hp_reg <= 1'b0;
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      hp_reg <= hp_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign pin_hp = hp_reg;
  assign in_level = s2_reg & (cfg.mode == MODE_IN);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // attempts from the last reset edge are skipped: the pad flops are still cleared there
  a_pin_follows_sel: assert property ((!rst && cfg.mode[1]) |=>
      (pin_oe && pin_out == $past(sel_bit)))
    else $error("pin does not follow selected signal");
  a_pin_input_dir: assert property ((!rst && cfg.mode == MODE_IN) |=> (!pin_oe && !pin_hp))
    else $error("input pin is driven");
  a_pin_high_power: assert property ((!rst && cfg.mode == MODE_OUT_HP) |=>
      (pin_oe && pin_hp))
    else $error("high power drive missing");

endmodule // pin_cell
`default_nettype wire

// ### hw/irq_and_gpio_routing.sv
// event flag aggregation, interrupt masking and four-pin signal routing
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - packet events: data sent bit 2, fifo error 5, almost full 7, almost empty 8
// - bit 16 sets on entering ready once the oscillator has settled
// - bits 17..21: standby switching, low battery, power-on reset, brownout, lock
// - status register clears when software reads it
// - each event holds its status bit high until cleared
// - mask bit zero suppresses that event's interrupt request
// - output selection 0 drives the combined active-low interrupt request
// - four pins, each configured independently
// - selections 1..3: power-on reset low, wakeup timer expired, battery low
// - selection 4 transmit data clock, 5 transmit state
// - selection 6 fifo almost empty, 7 almost full
// - selection 18 range extender, 19 constant high, 20 constant low
// - selections 21..24: regulator enable, sleep/standby, ready, lock
// - selections 25..29 and 31 expose sequencer wait phases, 30 synthesizer full enable
// - input selection 2 carries direct-mode transmit data
// - input selection 3 is an external wakeup event
// - input selection 4 is the 34.7 kHz low duty cycle clock
// - direction field: 01 input, 10 low-power output, 11 high-power output
// - read-and-reset registers clear automatically after a read
module irq_and_gpio_routing
  import irq_gpio_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // device core events and state
  input wire evt_t EVENTS,
  input wire ind_t IND,
  // pins
  input wire logic [NUM_PINS-1:0] GPIO_IN,
  output logic [NUM_PINS-1:0] GPIO_OUT,
  output logic [NUM_PINS-1:0] GPIO_OE,
  output logic [NUM_PINS-1:0] GPIO_HP,
  // functions towards the device core
  output logic IRQ_REQUEST_N,
  output logic TX_CMD,
  output logic DIRECT_DATA,
  output logic DIRECT_DATA_STROBE,
  output logic WAKEUP,
  output logic EXT_LOW_DUTY_CYCLE_TICK
);

  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] mask_reg, mask_next;
  pin_cfg_t cfg_reg [NUM_PINS];
  pin_cfg_t cfg_next [NUM_PINS];
  logic [31:0] evt_vec, status_flags, status_clr, out_vec;
  logic irq_n_reg, irq_n_next;
  logic [NUM_PINS-1:0] in_level;
  logic tx_cmd_level, tx_data_level, wake_level, ext_clk_level;
  logic [3:0] func_prev_reg, func_prev_next;
  logic tx_clk_prev_reg, tx_clk_prev_next;
  logic tx_cmd_reg, tx_cmd_next, wake_reg, wake_next, tick_reg, tick_next;
  logic data_reg, data_next, strobe_reg, strobe_next;

  // handshake readies: one write and one read in flight
  assign AWREADY = !aw_have_reg && !bvalid_reg;
  assign WREADY = !w_have_reg && !bvalid_reg;
  assign ARREADY = !rvalid_reg;

  // write channel: address and data taken in any order, applied together
  always_comb begin
    logic hit;
    hit = 1'b0;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    mask_next = mask_reg;
    cfg_next = cfg_reg;
    if (AWVALID && AWREADY) begin
      aw_have_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_have_next = 1'b1;
      w_data_next = WDATA;
      w_strb_next = WSTRB;
    end
    if (bvalid_reg && BREADY) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      // status and level words are read-only; writes there are dropped
      hit = (aw_addr_reg == ADDR_STATUS) || (aw_addr_reg == ADDR_PIN_LEVEL);
      // enable bits written per byte lane
      if (aw_addr_reg == ADDR_MASK) begin
        hit = 1'b1;
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            mask_next[8*b +: 8] = w_data_reg[8*b +: 8];
          end
        end
      end
      // each pin has its own configuration word
      for (int p = 0; p < NUM_PINS; p++) begin
        if (aw_addr_reg == ADDR_PIN_CFG0 + ADDR_PIN_STRIDE * 8'(p)) begin
          hit = 1'b1;
          if (w_strb_reg[0]) begin
            cfg_next[p] = pin_cfg_t'({w_data_reg[7:3], 1'b0, w_data_reg[1:0]});
          end
        end
      end
      bresp_next = hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel; a status read returns the flags and clears what it returned
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    status_clr = '0;
    if (rvalid_reg && RREADY) begin
      rvalid_next = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_next = 1'b1;
      rdata_next = '0;
      rresp_next = RESP_SLVERR;
      // clear exactly the bits handed out
      if (ARADDR == ADDR_STATUS) begin
        rdata_next = status_flags;
        rresp_next = RESP_OKAY;
        status_clr = status_flags;
      end
      if (ARADDR == ADDR_MASK) begin
        rdata_next = mask_reg;
        rresp_next = RESP_OKAY;
      end
      if (ARADDR == ADDR_PIN_LEVEL) begin
        rdata_next[NUM_PINS-1:0] = GPIO_OUT;
        rdata_next[2*NUM_PINS-1:NUM_PINS] = in_level;
        rresp_next = RESP_OKAY;
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        if (ARADDR == ADDR_PIN_CFG0 + ADDR_PIN_STRIDE * 8'(p)) begin
          rdata_next[7:0] = cfg_reg[p];
          rresp_next = RESP_OKAY;
        end
      end
    end
  end

  // all eleven core events placed in the event vector; unused bits stay zero
  always_comb begin
    evt_vec = '0;
    evt_vec[EVB_TX_SENT] = EVENTS.tx_sent;
    evt_vec[EVB_FIFO_ERR] = EVENTS.fifo_err;
    evt_vec[EVB_FIFO_AFULL] = EVENTS.fifo_afull;
    evt_vec[EVB_FIFO_AEMPTY] = EVENTS.fifo_aempty;
    // core pulses this on ready entry after oscillator settled
    evt_vec[EVB_READY] = EVENTS.osc_ready;
    evt_vec[EVB_STANDBY_SW] = EVENTS.standby_sw;
    evt_vec[EVB_LOW_BATT] = EVENTS.low_batt;
    evt_vec[EVB_POR] = EVENTS.por;
    evt_vec[EVB_BROWNOUT] = EVENTS.brownout;
    evt_vec[EVB_LOCK] = EVENTS.lock;
    evt_vec[EVB_CIPHER_DONE] = EVENTS.cipher_done;
  end

  // sticky flags, set wins over the read clear
  event_latch #(.W(32)) u_status (
    .clk(REF_CLK),
    .rst(RST),
    .set(evt_vec),
    .clr(status_clr),
    .flags(status_flags)
  );

  // masked flags combine into one active-low request
  always_comb begin
    irq_n_next = ~|(status_flags & mask_reg);
  end

  // selectable output signals, index is the selection code
  always_comb begin
    out_vec = '0;
    // selection 0 is the interrupt request
    out_vec[0] = irq_n_reg;
    out_vec[1] = ~IND.por_active;
    out_vec[2] = IND.wakeup_timer_expired;
    out_vec[3] = IND.low_batt;
    out_vec[4] = IND.tx_data_clk;
    out_vec[5] = IND.tx_state;
    out_vec[6] = IND.fifo_aempty;
    out_vec[7] = IND.fifo_afull;
    out_vec[18] = IND.range_ext_tx;
    out_vec[19] = 1'b1;
    out_vec[20] = 1'b0;
    out_vec[21] = IND.switching_regulator_en;
    out_vec[22] = IND.sleep_or_standby;
    out_vec[23] = IND.ready_state;
    out_vec[24] = IND.lock_state;
    out_vec[25] = IND.wait_lock_det;
    out_vec[26] = IND.wait_lock_timer;
    out_vec[27] = IND.wait_osc_settled_signal;
    out_vec[28] = IND.wait_pm_settle;
    out_vec[29] = IND.wait_vco_cal;
    out_vec[30] = IND.synthesizer_full_en;
    out_vec[31] = IND.wait_rc_cal_done;
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pin_cell u_pin (
      .clk(REF_CLK),
      .rst(RST),
      .cfg(cfg_reg[p]),
      .out_vec(out_vec),
      .pin_in(GPIO_IN[p]),
      .pin_out(GPIO_OUT[p]),
      .pin_oe(GPIO_OE[p]),
      .pin_hp(GPIO_HP[p]),
      .in_level(in_level[p])
    );
  end

  // input functions: several pins on one function are or-ed together
  always_comb begin
    tx_cmd_level = 1'b0;
    tx_data_level = 1'b0;
    wake_level = 1'b0;
    ext_clk_level = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      tx_cmd_level = tx_cmd_level | (in_level[p] & (cfg_reg[p].sel == ISEL_TX_CMD));
      tx_data_level = tx_data_level | (in_level[p] & (cfg_reg[p].sel == ISEL_DIRECT_DATA));
      wake_level = wake_level | (in_level[p] & (cfg_reg[p].sel == ISEL_WAKEUP));
      ext_clk_level = ext_clk_level | (in_level[p] & (cfg_reg[p].sel == ISEL_EXT_CLK));
    end
  end

  // edge detection turns held levels into single commands
  always_comb begin
    func_prev_next = {ext_clk_level, wake_level, tx_data_level, tx_cmd_level};
    tx_clk_prev_next = IND.tx_data_clk;
    // a rising level issues one transmit command
    tx_cmd_next = tx_cmd_level & ~func_prev_reg[0];
    // wakeup on rising edge of the sensor input
    wake_next = wake_level & ~func_prev_reg[2];
    // one tick per slow clock period; the pin delay is negligible
    tick_next = ext_clk_level & ~func_prev_reg[3];
    data_next = data_reg;
    strobe_next = 1'b0;
    // sample direct data on the data clock rising edge
    if (IND.tx_data_clk && !tx_clk_prev_reg) begin
      data_next = tx_data_level;
      strobe_next = 1'b1;
    end
  end

  // all register state
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      mask_reg <= MASK_RESET;
      for (int p = 0; p < NUM_PINS; p++) begin
        cfg_reg[p] <= pin_cfg_t'(PIN_CFG_RESET);
      end
      irq_n_reg <= 1'b1;
      func_prev_reg <= '0;
      tx_clk_prev_reg <= 1'b0;
      tx_cmd_reg <= 1'b0;
      wake_reg <= 1'b0;
      tick_reg <= 1'b0;
      data_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mask_reg <= mask_next;
      cfg_reg <= cfg_next;
      irq_n_reg <= irq_n_next;
      func_prev_reg <= func_prev_next;
      tx_clk_prev_reg <= tx_clk_prev_next;
      tx_cmd_reg <= tx_cmd_next;
      wake_reg <= wake_next;
      tick_reg <= tick_next;
      data_reg <= data_next;
      strobe_reg <= strobe_next;
    end
  end

  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
  assign IRQ_REQUEST_N = irq_n_reg;
  assign TX_CMD = tx_cmd_reg;
  assign WAKEUP = wake_reg;
  assign EXT_LOW_DUTY_CYCLE_TICK = tick_reg;
  assign DIRECT_DATA = data_reg;
  assign DIRECT_DATA_STROBE = strobe_reg;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_status_read;
    ARVALID && ARREADY && (ARADDR == ADDR_STATUS) && (evt_vec == '0);
  endsequence
  sequence s_tx_rise;
    tx_cmd_level && !func_prev_reg[0];
  endsequence
  sequence s_clk_rise;
    IND.tx_data_clk && !tx_clk_prev_reg;
  endsequence

  a_data_sent_flag: assert property (EVENTS.tx_sent |=> status_flags[EVB_TX_SENT])
    else $error("data sent flag not at bit 2");
  a_ready_flag: assert property (EVENTS.osc_ready |=> status_flags[EVB_READY])
    else $error("ready flag not at bit 16");
  a_lock_flag: assert property (EVENTS.lock |=> status_flags[EVB_LOCK])
    else $error("lock flag not at bit 21");
  a_unused_zero: assert property ((status_flags & ~EVT_USED_MASK) == '0)
    else $error("unused event bit set");
  a_read_clears: assert property (s_status_read |=>
      (status_flags == '0) && RVALID && (RDATA == $past(status_flags)))
    else $error("status read did not clear");
  a_mask_blocks: assert property (((status_flags & mask_reg) == '0) |=> IRQ_REQUEST_N)
    else $error("masked event raised request");
  a_irq_asserts: assert property (((status_flags & mask_reg) != '0) |=> !IRQ_REQUEST_N)
    else $error("enabled event gave no request");
  a_tx_command: assert property (s_tx_rise |=> TX_CMD ##1 !TX_CMD)
    else $error("transmit command not one pulse");
  a_direct_sample: assert property (s_clk_rise |=>
      DIRECT_DATA_STROBE && (DIRECT_DATA == $past(tx_data_level)))
    else $error("direct data not sampled");
  a_wakeup_pulse: assert property ((wake_level && !func_prev_reg[2]) |=> WAKEUP)
    else $error("wakeup lost");
  a_slow_tick: assert property ((ext_clk_level && !func_prev_reg[3]) |=> EXT_LOW_DUTY_CYCLE_TICK)
    else $error("slow clock tick lost");

endmodule // irq_and_gpio_routing
`default_nettype wire

// ### verification/host_pins.sv
// host side of the four pads: drives inputs, sees what the device drives
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  // clock
  input wire logic clk,
  // device pad side
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  // host drive requests
  input wire logic [3:0] drv_en,
  input wire logic [3:0] drv_val,
  // resolved pad levels
  output logic [3:0] pad
);
  logic [3:0] float_reg = 4'h0;
  // undriven pads wander so a stale level is never mistaken for data
  always @(posedge clk) float_reg <= ~float_reg;
  // host levels held steady across the device sampling edge
  always_comb pad = (oe & out) | (~oe & drv_en & drv_val) | (~oe & ~drv_en & float_reg);
endmodule // host_pins
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for event flags, masking and pin routing
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_gpio_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic AWVALID = 1'b0;
  logic WVALID = 1'b0;
  logic ARVALID = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  evt_t EVENTS = '0;
  ind_t IND = '0;
  logic [3:0] GPIO_IN, GPIO_OUT, GPIO_OE, GPIO_HP;
  logic [3:0] drv_en = 4'h0;
  logic [3:0] drv_val = 4'h0;
  logic IRQ_REQUEST_N, TX_CMD, DIRECT_DATA, DIRECT_DATA_STROBE, WAKEUP, EXT_LOW_DUTY_CYCLE_TICK;
  logic [33:0] rq[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int pc[4] = '{0, 0, 0, 0};
  logic [31:0] rnd = 32'h355f_48ff;
  int pos[11] = '{2, 5, 7, 8, 16, 17, 18, 19, 20, 21, 30};
  int isel[3] = '{0, 3, 4};
  int pidx[3] = '{0, 2, 3};
  logic d;

  always #12.5 REF_CLK = ~REF_CLK;

  irq_and_gpio_routing irq_and_gpio_routing_inst (.REF_CLK(REF_CLK), .RST(RST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(1'b1), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(1'b1), .EVENTS(EVENTS), .IND(IND),
    .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .GPIO_HP(GPIO_HP),
    .IRQ_REQUEST_N(IRQ_REQUEST_N), .TX_CMD(TX_CMD), .DIRECT_DATA(DIRECT_DATA),
    .DIRECT_DATA_STROBE(DIRECT_DATA_STROBE), .WAKEUP(WAKEUP),
    .EXT_LOW_DUTY_CYCLE_TICK(EXT_LOW_DUTY_CYCLE_TICK));

  host_pins host_pins_inst (.clk(REF_CLK), .oe(GPIO_OE), .out(GPIO_OUT), .drv_en(drv_en),
    .drv_val(drv_val), .pad(GPIO_IN));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected pad level for an output selection
  function automatic logic exp_out(input int s, input logic [18:0] b);
    if (s == 1) return ~b[18];
    if (s >= 2 && s <= 7) return b[19 - s];
    if (s == 18) return b[11];
    if (s == 19) return 1'b1;
    if (s >= 21) return b[31 - s];
    return 1'b0;
  endfunction

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    forever begin
      @(posedge REF_CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
    check("bresp", 34'(BRESP), 34'(RESP_OKAY));
  endtask

  // the expectation is queued; the read monitor compares it
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    forever begin
      @(posedge REF_CLK);
      if (ARREADY === 1'b1) break;
    end
    ARVALID <= 1'b0;
    forever begin
      @(posedge REF_CLK);
      if (RVALID === 1'b1) break;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // read monitor and pulse counters
  always @(posedge REF_CLK) begin
    if (RVALID === 1'b1 && rq.size() > 0) check("rdata", {RRESP, RDATA}, rq.pop_front());
    if (TX_CMD === 1'b1) pc[0]++;
    if (DIRECT_DATA_STROBE === 1'b1) pc[1]++;
    if (WAKEUP === 1'b1) pc[2]++;
    if (EXT_LOW_DUTY_CYCLE_TICK === 1'b1) pc[3]++;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    cyc(2);
    RST <= 1'b0;
    cyc(3);
    // reset values and an unmapped place
    rd(ADDR_PIN_CFG0, {RESP_OKAY, 32'h0000_00A2});
    rd(ADDR_MASK, {RESP_OKAY, 32'h0000_0000});
    rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
    $display("test reset done");
    // each event latches its own bit, held, cleared by a read
    for (int i = 0; i < 11; i++) begin
      EVENTS <= evt_t'(11'h400 >> i);
      cyc(1);
      EVENTS <= '0;
      rnd = lfsr(rnd);
      cyc(int'(rnd[2:0]) + 1);
      rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0001 << pos[i]});
      rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0000});
    end
    $display("test events done");
    // masked and unmasked lock event on a pin with selection 0
    wr(ADDR_PIN_CFG0, 32'h0000_0002);
    for (int m = 1; m >= 0; m--) begin
      wr(ADDR_MASK, (rnd & 32'hFFDF_FFFF) | (32'(m) << 21));
      EVENTS <= evt_t'(11'h002);
      cyc(1);
      EVENTS <= '0;
      cyc(4);
      check("irq_n", 34'(IRQ_REQUEST_N), 34'(m == 0));
      check("pin0", 34'(GPIO_OUT[0]), 34'(m == 0));
      rd(ADDR_STATUS, {RESP_OKAY, 32'h0020_0000});
      cyc(4);
      check("irq_n_clr", 34'(IRQ_REQUEST_N), 34'h1);
    end
    $display("test irq done");
    // output selections 1 to 31 on rotating pins
    for (int s = 1; s < 32; s++) begin
      rnd = lfsr(rnd);
      IND <= ind_t'(rnd[18:0]);
      wr(ADDR_PIN_CFG0 + 8'(4 * (s % 4)), 32'((s << 3) | 2 | rnd[20]));
      cyc(2);
      check("out", 34'(GPIO_OUT[s % 4]), 34'(exp_out(s, rnd[18:0])));
      check("oe", 34'(GPIO_OE[s % 4]), 34'h1);
      check("hp", 34'(GPIO_HP[s % 4]), 34'(rnd[20]));
    end
    $display("test outputs done");
    // one pulse per rising input on pin 2
    // idle indications, so the data clock below always starts low
    IND <= '0;
    drv_en <= 4'hC;
    for (int k = 0; k < 3; k++) begin
      drv_val <= 4'h0;
      wr(8'h10, 32'((isel[k] << 3) | 1));
      cyc(4);
      pc[pidx[k]] = 0;
      drv_val <= 4'h4;
      cyc(8);
      check("pulses", 34'(pc[pidx[k]]), 34'h1);
    end
    // an output-mode pin ignores the command function, counted from the change on
    pc[0] = 0;
    wr(8'h10, 32'h0000_0002);
    cyc(12);
    check("no_cmd", 34'(pc[0]), 34'h0);
    // direct data on pin 3, held across the data clock rise
    wr(8'h14, 32'h0000_0011);
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      d = rnd[0];
      drv_val <= {d, 3'h0};
      cyc(4);
      pc[1] = 0;
      IND <= ind_t'(19'h0_8000);
      cyc(3);
      IND <= '0;
      cyc(2);
      check("data", 34'(DIRECT_DATA), 34'(d));
      check("strobe", 34'(pc[1]), 34'h1);
      // level word: pin 2 shows the idle request, pin 3 the synchronised data
      rd(ADDR_PIN_LEVEL, {RESP_OKAY, 24'h0, d, 7'h04});
    end
    $display("test inputs done");
    final_report();
  end
endmodule // tb
`default_nettype wire
